/* File: rtl/crt_timer.v */
// capture/reload timer: 16-bit counter with capture, auto-reload, down count and baud generator modes
// assumes an APB master on pclk, and raw asynchronous count and trigger pins
`timescale 1ns/1ps
`include "crt_defs.vh"

module crt_timer
(
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output wire [31:0] prdata,
   // external pins, asynchronous
   input  wire        trigger_pin,
   input  wire        count_input_pin,
   // serial port time base
   input  wire        other_timer_ovf,
   output wire        rx_time_base,
   output wire        tx_time_base,
   output wire        overflow_pulse,
   // interrupt request
   output wire        timer_irq
);

   // register index match on a word-aligned address inside the map window
   function hit;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
      end
   endfunction

   // any mapped register
   function mapped;
      input [11:0] addr;
      begin
         mapped = hit(addr, `CRT_IDX_CTRL) || hit(addr, `CRT_IDX_MODE) ||
                  hit(addr, `CRT_IDX_CAP_LO) || hit(addr, `CRT_IDX_CAP_HI) ||
                  hit(addr, `CRT_IDX_CNT_LO) || hit(addr, `CRT_IDX_CNT_HI) ||
                  hit(addr, `CRT_IDX_AUX);
      end
   endfunction

   // control fields
   reg         overflow_flag_q;
   reg         external_flag_q;
   reg         rx_baud_sel_q;
   reg         tx_baud_sel_q;
   reg         trigger_enable_q;
   reg         run_control_q;
   reg         source_select_q;
   reg         capture_reload_select_q;
   reg         capture_auto_clear_q;
   reg         down_count_enable_q;
   reg         tick_rate_select_q;
   reg         timer_interrupt_enable_q;
   // counting state
   reg  [15:0] count_q;
   reg  [15:0] count_d;
   reg  [15:0] cap_q;
   reg  [15:0] cap_d;
   reg  [3:0]  presc_q;
   reg         baud_phase_q;
   reg         ovf_pulse_q;
   reg  [31:0] prdata_q;
   // pin synchronisers: stage 0 only feeds stage 1
   reg  [1:0]  sync0_q;
   reg  [1:0]  sync1_q;
   reg  [1:0]  prev_q;

   // apb decode; with pready tied high a write commits at its first access edge,
   // and an unmapped address selects no register at all
   wire        setup_rd   = psel & ~penable & ~pwrite;
   wire        access     = psel & penable;
   wire        wr         = access & pwrite & mapped(paddr);
   wire        wr_ctrl    = wr & hit(paddr, `CRT_IDX_CTRL);
   wire        wr_mode    = wr & hit(paddr, `CRT_IDX_MODE);
   wire        wr_cap_lo  = wr & hit(paddr, `CRT_IDX_CAP_LO);
   wire        wr_cap_hi  = wr & hit(paddr, `CRT_IDX_CAP_HI);
   wire        wr_cnt_lo  = wr & hit(paddr, `CRT_IDX_CNT_LO);
   wire        wr_cnt_hi  = wr & hit(paddr, `CRT_IDX_CNT_HI);
   wire        wr_aux     = wr & hit(paddr, `CRT_IDX_AUX);

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped(paddr);
   assign prdata  = prdata_q;

   // two-flop synchronisers for trigger (bit 0) and count pin (bit 1)
   // reset to the idle-high level so a release of reset never looks like a fall
   wire [1:0] pins_raw = {count_input_pin, trigger_pin};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_sync
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sync0_q[gi] <= 1'b1;
               sync1_q[gi] <= 1'b1;
               prev_q[gi]  <= 1'b1;
            end
            else
            begin
               sync0_q[gi] <= pins_raw[gi];
               sync1_q[gi] <= sync0_q[gi];
               prev_q[gi]  <= sync1_q[gi];
            end
         end
      end
   endgenerate

   wire trig_level = sync1_q[0];
   wire trig_fall  = prev_q[0] & ~sync1_q[0];
   wire pin_fall   = prev_q[1] & ~sync1_q[1];

   // either time base select forces baud generator mode
   wire baud_mode   = rx_baud_sel_q | tx_baud_sel_q;
   // capture select only counts outside baud mode
   wire reload_mode = baud_mode | ~capture_reload_select_q;
   // trigger acts only when enabled and not making baud clocks
   wire trig_event  = trigger_enable_q & ~baud_mode & trig_fall;
   // up/down steering only in plain auto-reload with down count enabled
   wire down_mode   = down_count_enable_q & ~baud_mode & ~capture_reload_select_q;
   wire count_down  = down_mode & ~trig_level;

   // tick source; the prescaler keeps running while halted so rate is steady;
   // compare with >= so a switch to the fast rate never waits for a 4-bit wrap
   wire [3:0] presc_lim = tick_rate_select_q ? `CRT_DIV_FAST_M1 : `CRT_DIV_SLOW_M1;
   wire       presc_end = (presc_q >= presc_lim);
   reg  tick_src;
   always @*
   begin
      if (baud_mode)
         tick_src = baud_phase_q;
      else if (source_select_q)
         tick_src = pin_fall;
      else
         tick_src = presc_end;
   end
   wire tick = run_control_q & tick_src;

   // rollover conditions
   // up wrap after FFFFh; down wrap when the count meets the capture/reload value
   wire up_wrap   = tick & ~count_down & (count_q == `CRT_COUNT_MAX);
   wire down_wrap = tick & count_down & (count_q == cap_q);
   wire ovf_evt   = up_wrap | down_wrap;

   // prescaler and baud divider
   // the baud divider toggles every clock, giving one tick in two
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc_q      <= 4'h0;
         baud_phase_q <= 1'b0;
      end
      else
      begin
         presc_q      <= presc_end ? 4'h0 : presc_q + 4'h1;
         baud_phase_q <= ~baud_phase_q;
      end
   end

   // trigger capture; a tick in the same cycle still steps the count unless auto clear is set
   wire capture_now = trig_event & capture_reload_select_q;

   // next count, by precedence: capture, trigger reload, underflow, overflow, step;
   // a software write of either count byte then overrides the hardware result
   always @*
   begin
      count_d = count_q;
      if (capture_now)
      begin
         if (capture_auto_clear_q)
            count_d = `CRT_RST_COUNT;
         else if (tick)
            count_d = count_q + 16'h0001;
      end
      else if (trig_event && !down_mode)
         count_d = cap_q;
      else if (down_wrap)
         count_d = `CRT_COUNT_MAX;
      else if (up_wrap && reload_mode)
         count_d = cap_q;
      else if (tick && count_down)
         count_d = count_q - 16'h0001;
      else if (tick)
         count_d = count_q + 16'h0001;
      if (wr_cnt_lo)
         count_d[7:0] = pwdata[7:0];
      if (wr_cnt_hi)
         count_d[15:8] = pwdata[7:0];
   end

   // next capture value; a capture in the same cycle beats a software write of the pair
   always @*
   begin
      cap_d = cap_q;
      if (capture_now)
         cap_d = count_q;
      else
      begin
         if (wr_cap_lo)
            cap_d[7:0] = pwdata[7:0];
         if (wr_cap_hi)
            cap_d[15:8] = pwdata[7:0];
      end
   end

   // flag events
   wire ovf_set = ovf_evt & ~baud_mode;
   wire ext_set = trig_event | (down_mode & ovf_evt);

   // flag values after a software write of the control register, before hardware events
   wire ovf_flag_sw = wr_ctrl ? pwdata[`CRT_CTRL_OVF] : overflow_flag_q;
   wire ext_flag_sw = wr_ctrl ? pwdata[`CRT_CTRL_EXT] : external_flag_q;

   // count and capture pair, and the registered overflow pulse
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_q     <= `CRT_RST_COUNT;
         cap_q       <= `CRT_RST_COUNT;
         ovf_pulse_q <= 1'b0;
      end
      else
      begin
         count_q     <= count_d;
         cap_q       <= cap_d;
         ovf_pulse_q <= ovf_evt;                                         // high one cycle per rollover
      end
   end

   // status flags; the hardware set is ORed on top of the write,
   // so a clear in the same cycle as an event never hides it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         overflow_flag_q <= 1'b0;
         external_flag_q <= 1'b0;
      end
      else
      begin
         overflow_flag_q <= ovf_flag_sw | ovf_set;
         external_flag_q <= ext_flag_sw | ext_set;
      end
   end

   // mode and enable bits of the control register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_baud_sel_q           <= 1'b0;
         tx_baud_sel_q           <= 1'b0;
         trigger_enable_q        <= 1'b0;
         run_control_q           <= 1'b0;
         source_select_q         <= 1'b0;
         capture_reload_select_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         rx_baud_sel_q           <= pwdata[`CRT_CTRL_RXSEL];
         tx_baud_sel_q           <= pwdata[`CRT_CTRL_TXSEL];
         trigger_enable_q        <= pwdata[`CRT_CTRL_TRIG_EN];
         run_control_q           <= pwdata[`CRT_CTRL_RUN];
         source_select_q         <= pwdata[`CRT_CTRL_SRC];
         capture_reload_select_q <= pwdata[`CRT_CTRL_CAPSEL];
      end
   end

   // timer_mode_control bits
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capture_auto_clear_q <= 1'b0;
         down_count_enable_q  <= 1'b0;
      end
      else if (wr_mode)
      begin
         capture_auto_clear_q <= pwdata[`CRT_MODE_AUTOCLR];
         down_count_enable_q  <= pwdata[`CRT_MODE_DOWN_EN];
      end
   end

   // aux bits: tick rate and interrupt enable, kept here as this block has no clock or interrupt unit
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_rate_select_q       <= 1'b0;
         timer_interrupt_enable_q <= 1'b0;
      end
      else if (wr_aux)
      begin
         tick_rate_select_q       <= pwdata[`CRT_AUX_TICK_RATE];
         timer_interrupt_enable_q <= pwdata[`CRT_AUX_IRQ_EN];
      end
   end

   // read mux, loaded in the setup cycle so data stands from flops during access
   wire [7:0] ctrl_rd = {overflow_flag_q, external_flag_q, rx_baud_sel_q, tx_baud_sel_q,
                         trigger_enable_q, run_control_q, source_select_q, capture_reload_select_q};
   reg  [7:0] rd_byte;
   always @*
   begin
      rd_byte = `CRT_RST_BYTE;
      if (hit(paddr, `CRT_IDX_CTRL))
         rd_byte = ctrl_rd;
      else if (hit(paddr, `CRT_IDX_MODE))
         rd_byte = {6'h00, capture_auto_clear_q, down_count_enable_q};
      else if (hit(paddr, `CRT_IDX_CAP_LO))
         rd_byte = cap_q[7:0];
      else if (hit(paddr, `CRT_IDX_CAP_HI))
         rd_byte = cap_q[15:8];
      else if (hit(paddr, `CRT_IDX_CNT_LO))
         rd_byte = count_q[7:0];
      else if (hit(paddr, `CRT_IDX_CNT_HI))
         rd_byte = count_q[15:8];
      else if (hit(paddr, `CRT_IDX_AUX))
         rd_byte = {6'h00, timer_interrupt_enable_q, tick_rate_select_q};
   end

   // read data register, loaded only by a read setup so data stands through the access
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else if (setup_rd)
         prdata_q <= {24'h000000, rd_byte};
   end

   // registered overflow pulse, so the serial port sees a clean one-cycle strobe
   assign overflow_pulse = ovf_pulse_q;

   // serial time base: this timer only when selected, else the other timer
   assign rx_time_base   = rx_baud_sel_q ? ovf_pulse_q : other_timer_ovf;
   assign tx_time_base   = tx_baud_sel_q ? ovf_pulse_q : other_timer_ovf;

   // request held by either flag, forwarded only when enabled
   // a level: it stays up until software clears both flags or the enable
   assign timer_irq = timer_interrupt_enable_q & (overflow_flag_q | external_flag_q);

endmodule // crt_timer

/* File: inc/crt_defs.vh */
// register indices, field positions, reset values and tick divisors of the capture/reload timer
// assumes an APB slave in which byte address = 4 * register index
`ifndef CRT_DEFS_VH
`define CRT_DEFS_VH

// register indices (byte address is four times these)
`define CRT_IDX_CTRL       8'hC8
`define CRT_IDX_MODE       8'hC9
`define CRT_IDX_CAP_LO     8'hCA
`define CRT_IDX_CAP_HI     8'hCB
`define CRT_IDX_CNT_LO     8'hCC
`define CRT_IDX_CNT_HI     8'hCD
`define CRT_IDX_AUX        8'hCE

// timer_control fields
`define CRT_CTRL_OVF       7
`define CRT_CTRL_EXT       6
`define CRT_CTRL_RXSEL     5
`define CRT_CTRL_TXSEL     4
`define CRT_CTRL_TRIG_EN   3
`define CRT_CTRL_RUN       2
`define CRT_CTRL_SRC       1
`define CRT_CTRL_CAPSEL    0

// timer_mode_control fields
`define CRT_MODE_AUTOCLR   1
`define CRT_MODE_DOWN_EN   0

// aux register fields
`define CRT_AUX_TICK_RATE  0
`define CRT_AUX_IRQ_EN     1

// reset values
`define CRT_RST_BYTE       8'h00
`define CRT_RST_COUNT      16'h0000

// count limits
`define CRT_COUNT_MAX      16'hFFFF

// internal tick divisors in core clocks, minus one
`define CRT_DIV_SLOW_M1    4'hB
`define CRT_DIV_FAST_M1    4'h3

`endif

/* File: tb/crt_timer_properties.sv */
// port checker for the capture/reload timer, bound onto crt_timer
// assumes one pclk domain and byte address = 4 * register index
`timescale 1ns/1ps
`include "crt_defs.vh"
module crt_timer_chk
(
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   input wire [31:0] prdata,
   // pins and time base
   input wire        trigger_pin,
   input wire        count_input_pin,
   input wire        other_timer_ovf,
   input wire        rx_time_base,
   input wire        tx_time_base,
   input wire        overflow_pulse,
   input wire        timer_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg [7:0] ctrl_q;
   reg       irq_en_q;
   wire      wr_acc = psel && penable && pwrite;
   // shadow of software writes only; hardware flag updates are not needed here
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q   <= 8'h00;
         irq_en_q <= 1'b0;
      end
      else if (wr_acc && paddr == {2'b00, `CRT_IDX_CTRL, 2'b00})
         ctrl_q <= pwdata[7:0];
      else if (wr_acc && paddr == {2'b00, `CRT_IDX_AUX, 2'b00})
         irq_en_q <= pwdata[`CRT_AUX_IRQ_EN];
   end
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_err_read;
      s_access ##0 (!pwrite && pslverr);
   endsequence
   AST_READY: assert property (s_access |-> pready) else $error("pready low in access");
   AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
   AST_ERR_ZERO: assert property (s_err_read |-> prdata == 32'h0) else $error("refused read not zero");
   AST_UPPER: assert property (s_access |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   AST_RX_BASE: assert property ($stable(ctrl_q[5]) |->
      rx_time_base == (ctrl_q[5] ? overflow_pulse : other_timer_ovf)) else $error("rx time base wrong");
   AST_TX_BASE: assert property ($stable(ctrl_q[4]) |->
      tx_time_base == (ctrl_q[4] ? overflow_pulse : other_timer_ovf)) else $error("tx time base wrong");
   AST_HALT: assert property (!ctrl_q[2] && !$past(ctrl_q[2]) && !$past(ctrl_q[2], 2) |-> !overflow_pulse)
      else $error("overflow while halted");
   AST_IRQ_MASK: assert property (!irq_en_q && $stable(irq_en_q) |-> !timer_irq) else $error("irq while masked");
   AST_PULSE: assert property (overflow_pulse |=> !overflow_pulse) else $error("overflow pulse too long");
endmodule // crt_timer_chk
bind crt_timer crt_timer_chk u_crt_timer_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .trigger_pin(trigger_pin), .count_input_pin(count_input_pin), .other_timer_ovf(other_timer_ovf),
   .rx_time_base(rx_time_base), .tx_time_base(tx_time_base), .overflow_pulse(overflow_pulse),
   .timer_irq(timer_irq));

/* File: tb/crt_pin_model.sv */
// far-side model: trigger and count pins, other timer overflow, serial time base counters
// assumes the timer synchronises both pins itself; pins idle high so only real falls act
`timescale 1ns/1ps
module crt_pin_model
(
   // clock
   input wire pclk,
   // pins toward the timer
   output reg trigger_pin,
   output reg count_input_pin,
   output reg other_timer_ovf,
   // serial time base seen by the port
   input wire rx_time_base,
   input wire tx_time_base
);
   integer   tx_cnt;
   integer   rx_cnt;
   reg [2:0] div_q;
   initial
   begin
      trigger_pin = 1'b1;
      count_input_pin = 1'b1;
      other_timer_ovf = 1'b0;
      div_q = 3'h0;
      tx_cnt = 0;
      rx_cnt = 0;
   end
   // other timer overflows every eight clocks; port counts time base pulses
   always @(posedge pclk)
   begin
      div_q <= div_q + 3'h1;
      other_timer_ovf <= (div_q == 3'h7);
      if (tx_time_base === 1'b1)
         tx_cnt <= tx_cnt + 1;
      if (rx_time_base === 1'b1)
         rx_cnt <= rx_cnt + 1;
   end
   // held low eight clocks so the synchroniser cannot miss it
   task trig_fall;
      begin
         @(posedge pclk);
         trigger_pin <= 1'b0;
         repeat (8) @(posedge pclk);
         trigger_pin <= 1'b1;
         repeat (8) @(posedge pclk);
      end
   endtask
   task trig_level(input reg lvl);
      begin
         @(posedge pclk);
         trigger_pin <= lvl;
         repeat (4) @(posedge pclk);
      end
   endtask
   task cnt_pulses(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            @(posedge pclk);
            count_input_pin <= 1'b0;
            repeat (4) @(posedge pclk);
            count_input_pin <= 1'b1;
            repeat (4) @(posedge pclk);
         end
      end
   endtask
endmodule // crt_pin_model

/* File: tb/tb_crt_timer.sv */
// self-checking bench for crt_timer: apb register tests plus pin and baud scenarios
// assumes crt_pin_model on the far side and the bound port checker
`timescale 1ns/1ps
`include "crt_defs.vh"
module tb_crt_timer;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   wire        pready, pslverr, trigger_pin, count_input_pin, other_timer_ovf;
   wire        rx_time_base, tx_time_base, overflow_pulse, timer_irq;
   wire [31:0] prdata;
   integer     num_errors = 0;
   integer     num_checks = 0;
   integer     cyc = 0;
   integer     i, t0, r0;
   reg  [7:0]  rd;
   reg         err;
   crt_timer u_crt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .trigger_pin(trigger_pin), .count_input_pin(count_input_pin), .other_timer_ovf(other_timer_ovf),
      .rx_time_base(rx_time_base), .tx_time_base(tx_time_base), .overflow_pulse(overflow_pulse),
      .timer_irq(timer_irq));
   crt_pin_model u_crt_pin_model (.pclk(pclk), .trigger_pin(trigger_pin), .count_input_pin(count_input_pin),
      .other_timer_ovf(other_timer_ovf), .rx_time_base(rx_time_base), .tx_time_base(tx_time_base));
   // 25 MHz core clock
   always #20 pclk = ~pclk;
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // hang guard, far above the several hundred cycles the tests need
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   task check(input reg [7:0] got, input reg [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            num_errors = num_errors + 1;
         end
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task apb(input reg wr, input reg [7:0] idx, input reg [7:0] wd);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= {2'b00, idx, 2'b00};
         pwdata <= {24'h0, wd};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata[7:0];
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input reg [7:0] idx, input reg [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task rdchk(input reg [7:0] idx, input reg [7:0] exp);
      begin
         apb(1'b0, idx, 8'h00);
         check(rd, exp);
      end
   endtask
   task irqchk(input reg exp);
      begin
         @(negedge pclk);
         check({7'h0, timer_irq}, {7'h0, exp});
      end
   endtask
   task cnt_set(input reg [7:0] hi, input reg [7:0] lo);
      begin
         wr(`CRT_IDX_CNT_LO, lo);
         wr(`CRT_IDX_CNT_HI, hi);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 7; i = i + 1)
         rdchk(`CRT_IDX_CTRL + i, `CRT_RST_BYTE);
      apb(1'b0, 8'hFF, 8'h00);
      check({7'h0, err}, 8'h01);
      cnt_set(8'h12, 8'h34);
      rdchk(`CRT_IDX_CNT_LO, 8'h34);
      rdchk(`CRT_IDX_CNT_HI, 8'h12);
      $display("test 1 done");
      // external count pin edges, internal ticks off
      cnt_set(8'h00, 8'h00);
      wr(`CRT_IDX_CTRL, 8'h06);
      u_crt_pin_model.cnt_pulses(3);
      wr(`CRT_IDX_CTRL, 8'h00);
      rdchk(`CRT_IDX_CNT_LO, 8'h03);
      $display("test 2 done");
      // direction follows trigger level with down count on, then halt holds count
      wr(`CRT_IDX_AUX, 8'h01);
      wr(`CRT_IDX_MODE, 8'h01);
      for (i = 0; i < 2; i = i + 1)
      begin
         u_crt_pin_model.trig_level(i == 0);
         cnt_set(8'h80, 8'h00);
         wr(`CRT_IDX_CTRL, 8'h04);
         repeat (40) @(posedge pclk);
         wr(`CRT_IDX_CTRL, 8'h00);
         rdchk(`CRT_IDX_CNT_HI, (i == 0) ? 8'h80 : 8'h7F);
         apb(1'b0, `CRT_IDX_CNT_LO, 8'h00);
         t0 = rd;
         repeat (30) @(posedge pclk);
         rdchk(`CRT_IDX_CNT_LO, t0[7:0]);
      end
      u_crt_pin_model.trig_level(1'b1);
      wr(`CRT_IDX_MODE, 8'h00);
      $display("test 3 done");
      // up overflow reloads from capture/reload pair and sets the flag
      wr(`CRT_IDX_CAP_LO, 8'h34);
      wr(`CRT_IDX_CAP_HI, 8'h12);
      cnt_set(8'hFF, 8'hFE);
      wr(`CRT_IDX_CTRL, 8'h04);
      i = 0;
      while (overflow_pulse !== 1'b1 && i < 300)
      begin
         @(negedge pclk);
         i = i + 1;
      end
      check({7'h0, overflow_pulse}, 8'h01);
      rdchk(`CRT_IDX_CTRL, 8'h84);
      wr(`CRT_IDX_CTRL, 8'h00);
      rdchk(`CRT_IDX_CNT_HI, 8'h12);
      rdchk(`CRT_IDX_CTRL, 8'h00);
      $display("test 4 done");
      // capture with auto clear, then interrupt mask, clear and software set
      wr(`CRT_IDX_MODE, 8'h02);
      cnt_set(8'hBE, 8'hEF);
      wr(`CRT_IDX_CTRL, 8'h09);
      u_crt_pin_model.trig_fall;
      rdchk(`CRT_IDX_CAP_LO, 8'hEF);
      rdchk(`CRT_IDX_CAP_HI, 8'hBE);
      rdchk(`CRT_IDX_CNT_LO, 8'h00);
      rdchk(`CRT_IDX_CNT_HI, 8'h00);
      rdchk(`CRT_IDX_CTRL, 8'h49);
      irqchk(1'b0);
      wr(`CRT_IDX_AUX, 8'h03);
      irqchk(1'b1);
      wr(`CRT_IDX_CTRL, 8'h08);
      irqchk(1'b0);
      wr(`CRT_IDX_CTRL, 8'h48);
      irqchk(1'b1);
      wr(`CRT_IDX_CTRL, 8'h08);
      wr(`CRT_IDX_MODE, 8'h00);
      $display("test 5 done");
      // trigger reload when enabled, ignored when not
      cnt_set(8'h00, 8'h01);
      u_crt_pin_model.trig_fall;
      rdchk(`CRT_IDX_CNT_LO, 8'hEF);
      rdchk(`CRT_IDX_CNT_HI, 8'hBE);
      rdchk(`CRT_IDX_CTRL, 8'h48);
      wr(`CRT_IDX_CTRL, 8'h00);
      cnt_set(8'h00, 8'h05);
      u_crt_pin_model.trig_fall;
      rdchk(`CRT_IDX_CNT_LO, 8'h05);
      rdchk(`CRT_IDX_CTRL, 8'h00);
      $display("test 6 done");
      // baud generator: reload FFFE, one step per two clocks, overflow every four
      wr(`CRT_IDX_CAP_LO, 8'hFE);
      wr(`CRT_IDX_CAP_HI, 8'hFF);
      cnt_set(8'hFF, 8'hFE);
      wr(`CRT_IDX_CTRL, 8'h35);
      repeat (8) @(posedge pclk);
      t0 = u_crt_pin_model.tx_cnt;
      r0 = u_crt_pin_model.rx_cnt;
      repeat (80) @(posedge pclk);
      t0 = u_crt_pin_model.tx_cnt - t0;
      r0 = u_crt_pin_model.rx_cnt - r0;
      check({7'h0, t0 >= 19 && t0 <= 21}, 8'h01);
      check(r0[7:0], t0[7:0]);
      rdchk(`CRT_IDX_CTRL, 8'h35);
      wr(`CRT_IDX_CTRL, 8'h00);
      $display("test 7 done");
      // down count underflow at the slow tick rate: match loads FFFF and sets both flags
      wr(`CRT_IDX_AUX, 8'h02);
      wr(`CRT_IDX_MODE, 8'h01);
      u_crt_pin_model.trig_level(1'b0);
      wr(`CRT_IDX_CAP_LO, 8'h05);
      wr(`CRT_IDX_CAP_HI, 8'h00);
      cnt_set(8'h00, 8'h06);
      wr(`CRT_IDX_CTRL, 8'h04);
      i = 0;
      while (overflow_pulse !== 1'b1 && i < 300)
      begin
         @(negedge pclk);
         i = i + 1;
      end
      check({7'h0, i >= 14 && i <= 25}, 8'h01);
      rdchk(`CRT_IDX_CTRL, 8'hC4);
      wr(`CRT_IDX_CTRL, 8'h00);
      rdchk(`CRT_IDX_CNT_HI, 8'hFF);
      u_crt_pin_model.trig_level(1'b1);
      wr(`CRT_IDX_MODE, 8'h00);
      $display("test 8 done");
      end_sim;
   end
endmodule // tb_crt_timer
